// file: verification/tas_sense_model.sv
// Model: analog sense codes feeding the sequencer
`timescale 1ns/1ps
module tas_sense_model #(
  parameter int NP = 2,
  parameter logic [11:0] KT = 12'hCB0,
  parameter logic [11:0] KVL = 12'hAAA,
  parameter logic [11:0] KVH = 12'hD55,
  parameter logic [11:0] KI = 12'h810,
  parameter logic [11:0] KVO = 12'h900,
  parameter logic [11:0] KS = 12'h840
) (
  input wire logic [11:0] shift,
  output logic [11:0] temp_code,
  output logic [11:0] vin_code_lo,
  output logic [11:0] vin_code_hi,
  output logic [NP*12-1:0] iret_code,
  output logic [NP*12-1:0] vout_code_lo,
  output logic [NP*12-1:0] vout_code_hi,
  output logic [NP*12-1:0] isrc_code
);
  // Codes sit above mid-scale so offset coding shows
  assign temp_code = KT + shift;
  assign vin_code_lo = KVL + shift;
  assign vin_code_hi = KVH + shift;
  for (genvar p = 0; p < NP; p++) begin : g_port
    assign iret_code[p*12+:12] = KI + 12'(p) + shift;
    assign vout_code_lo[p*12+:12] = KVO + 12'(p) + shift;
    assign vout_code_hi[p*12+:12] = KVH + 12'(p) + shift;
    assign isrc_code[p*12+:12] = KS + 12'(p) + shift;
  end
endmodule : tas_sense_model

// file: verification/tas_seq_asserts.sv
// Checker: port-level properties of the telemetry sequencer
`timescale 1ns/1ps
module tas_seq_asserts #(
  parameter int NPORTS = 5
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NPORTS-1:0] port_powering,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic acc;
  assign acc = psel && penable;
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_mask_off;
    acc && pwrite && paddr == tas_pkg::OFF_IRQ_EN && pwdata == 32'h0;
  endsequence
  sequence s_pstate_rd;
    acc && !pwrite && paddr == tas_pkg::OFF_PSTATE;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_PREADY: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  AST_BAD_ERR: assert property (acc && paddr >= 8'h30 |-> pslverr)
    else $error("no error on unmapped address");
  AST_BAD_ZERO: assert property (acc && paddr >= 8'h30 |-> prdata == 0)
    else $error("unmapped read not zero");
  AST_GDAT_OK: assert property (
    acc && paddr == tas_pkg::OFF_GDAT |-> !pslverr)
    else $error("error on result register");
  AST_CLR_ZERO: assert property (acc && !pwrite &&
    paddr == tas_pkg::OFF_IRQ_CLR |-> prdata == 32'h0)
    else $error("clear register reads nonzero");
  AST_GDAT_TOP: assert property (acc && !pwrite &&
    paddr == tas_pkg::OFF_GDAT |-> prdata[31:13] == 0)
    else $error("result upper bits set");
  // Readback lags the pin by the two sync stages
  AST_PSTATE: assert property (s_pstate_rd ##0
    port_powering == $past(port_powering, 1) &&
    port_powering == $past(port_powering, 2) |->
    prdata[NPORTS-1:0] == port_powering)
    else $error("port state readback wrong");
  AST_MASK: assert property (s_mask_off |-> ##[1:3] !irq)
    else $error("irq stays high when masked");
  AST_IRQ_RST: assert property ($fell(reset) |-> !irq)
    else $error("irq high after reset");
endmodule : tas_seq_asserts

bind tas_sequencer tas_seq_asserts #(.NPORTS(NPORTS)) i_tas_seq_asserts (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .port_powering(port_powering),
  .irq(irq));

// file: verification/tas_sequencer_tb.sv
// Testbench: register-level tests of the telemetry sequencer
`timescale 1ns/1ps
module tas_sequencer_tb;
  localparam int NP = 2;
  localparam int FC = 40;
  localparam int RC = 20;
  localparam logic [11:0] KT = 12'hCB0;
  localparam logic [11:0] KVL = 12'hAAA;
  localparam logic [11:0] KVH = 12'hD55;
  localparam logic [11:0] KI = 12'h810;
  localparam logic [11:0] KVO = 12'h900;
  localparam logic [11:0] KS = 12'h840;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic er;
  logic [11:0] shift = 12'h000, tc, vl, vh;
  logic [NP*12-1:0] ir, vol, voh, is;
  logic [NP-1:0] port_powering = '0;
  int bad_count = 0, samples_checked = 0, cyc = 0, t0;
  logic [3:0] sels [6] = '{tas_pkg::SEL_TEMP, tas_pkg::SEL_VIN,
    tas_pkg::SEL_IRET0, 4'h3, tas_pkg::SEL_VOUT0, 4'h9};
  logic [11:0] exps [6] = '{KT, KVL, KI, KI + 12'h001, KVO, 12'h901};
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  tas_sense_model #(.NP(NP), .KT(KT), .KVL(KVL), .KVH(KVH), .KI(KI),
    .KVO(KVO), .KS(KS)) i_tas_sense_model (.shift(shift),
    .temp_code(tc), .vin_code_lo(vl), .vin_code_hi(vh), .iret_code(ir),
    .vout_code_lo(vol), .vout_code_hi(voh), .isrc_code(is));
  tas_sequencer #(.NPORTS(NP), .FIRST_CYC(FC), .REFRESH_CYC(RC))
    i_tas_sequencer (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .temp_code(tc),
    .vin_code_lo(vl), .vin_code_hi(vh), .iret_code(ir),
    .vout_code_lo(vol), .vout_code_hi(voh), .isrc_code(is),
    .port_powering(port_powering), .irq(irq));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // Request holds until pready is seen high; data taken at that edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_new(input int lim);
    int n;
    n = 0;
    apb(1'b0, tas_pkg::OFF_GDAT, 32'h0);
    while (rd[12] !== 1'b1 && n < lim) begin
      apb(1'b0, tas_pkg::OFF_GDAT, 32'h0);
      n++;
    end
  endtask : wait_new
  task single(input logic [3:0] sel, input logic [11:0] e);
    apb(1'b1, tas_pkg::OFF_GCFG, {24'h0, 8'h90 | 8'(sel)});
    t0 = cyc;
    apb(1'b0, tas_pkg::OFF_GDAT, 32'h0);
    chk("early_new", rd[12], 1'b0);
    wait_new(40);
    chk("latency", (cyc - t0 >= FC) && (cyc - t0 <= FC + 8), 1'b1);
    chk("result", rd[12:0], {1'b1, e});
    repeat (2 * RC) @(posedge core_clk);
    apb(1'b0, tas_pkg::OFF_GDAT, 32'h0);
    chk("held", rd[12:0], {1'b0, e});
  endtask : single
  task tally_and_finish;
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    apb(1'b0, tas_pkg::OFF_GCFG, 32'h0);
    chk("gcfg_rst", rd[7:0], tas_pkg::GCFG_RESET);
    apb(1'b0, tas_pkg::OFF_GDAT, 32'h0);
    chk("gdat_rst", rd[12:0], tas_pkg::GDAT_RESET);
    for (int i = 0; i < 6; i++) single(sels[i], exps[i]);
    apb(1'b1, tas_pkg::OFF_GCFG, 32'hE1);
    wait_new(40);
    chk("vin_high", rd[11:0], KVH);
    t0 = cyc;
    shift <= 12'h005;
    wait_new(20);
    chk("refresh", rd[11:0], KVH + 12'h005);
    chk("period", (cyc - t0 >= RC - 4) && (cyc - t0 <= RC + 4), 1'b1);
    apb(1'b1, tas_pkg::OFF_GCFG, 32'hE9);
    wait_new(40);
    chk("vout_high", rd[11:0], KVH + 12'h006);
    apb(1'b1, tas_pkg::OFF_GCFG, 32'h01);
    repeat (3 * RC) @(posedge core_clk);
    apb(1'b0, tas_pkg::OFF_GDAT, 32'h0);
    chk("stopped", rd[12], 1'b0);
    port_powering <= 2'b01;
    repeat (3 * RC) @(posedge core_clk);
    apb(1'b0, tas_pkg::OFF_PDAT0, 32'h0);
    chk("pdat0", rd[11:0], KS + 12'h005);
    apb(1'b0, tas_pkg::OFF_PDAT0 + 8'h04, 32'h0);
    chk("pdat1", rd[11:0], tas_pkg::CODE_MID);
    apb(1'b0, tas_pkg::OFF_PSTATE, 32'h0);
    chk("pstate", rd[1:0], 2'b01);
    apb(1'b1, tas_pkg::OFF_IRQ_CLR, 32'h7);
    apb(1'b1, tas_pkg::OFF_IRQ_EN, 32'h1);
    @(posedge core_clk);
    chk("irq_idle", irq, 1'b0);
    single(tas_pkg::SEL_TEMP, KT + 12'h005);
    chk("irq_on", irq, 1'b1);
    apb(1'b1, tas_pkg::OFF_IRQ_STAT, 32'h0);
    apb(1'b0, tas_pkg::OFF_IRQ_STAT, 32'h0);
    chk("stat_ro", rd[0], 1'b1);
    apb(1'b1, tas_pkg::OFF_IRQ_EN, 32'h0);
    apb(1'b1, tas_pkg::OFF_IRQ_EN, 32'h1);
    apb(1'b1, tas_pkg::OFF_IRQ_CLR, 32'h1);
    apb(1'b0, tas_pkg::OFF_IRQ_STAT, 32'h0);
    chk("stat_clr", rd[0], 1'b0);
    chk("irq_clr", irq, 1'b0);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped_err", er, 1'b1);
    chk("unmapped_rd", rd, 32'h00000000);
    tally_and_finish;
  end
endmodule : tas_sequencer_tb

// file: verilog/tas_pkg.sv
// Package: constants for the telemetry conversion sequencer
package tas_pkg;
  // APB register offsets (byte addresses)
  localparam logic [7:0] OFF_GCFG = 8'h00;
  localparam logic [7:0] OFF_GDAT = 8'h04;
  localparam logic [7:0] OFF_PDAT0 = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFF_IRQ_EN = 8'h24;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h28;
  localparam logic [7:0] OFF_PSTATE = 8'h2C;

  // Config and data field positions
  localparam int GCFG_SEL_LSB = 0;
  localparam int GCFG_SEL_W = 4;
  localparam int GCFG_MODE_LSB = 4;
  localparam int GCFG_GAIN_BIT = 6;
  localparam int GCFG_START_BIT = 7;
  localparam int GDAT_NEW_BIT = 12;

  // Sampling modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;

  // Input selector codes; ports add their index
  localparam logic [3:0] SEL_TEMP = 4'h0;
  localparam logic [3:0] SEL_VIN = 4'h1;
  localparam logic [3:0] SEL_IRET0 = 4'h2;
  localparam logic [3:0] SEL_VOUT0 = 4'h8;

  // Result coding: offset binary about mid-scale
  localparam logic [11:0] CODE_MID = 12'h800;
  localparam logic [11:0] GDAT_RESET = 12'h800;

  // Reset values
  localparam logic [7:0] GCFG_RESET = 8'h00;

  // Timing
  localparam real CLK_MHZ = 40.0;
  localparam real T_FIRST_MS = 3.6;
  localparam real T_REFRESH_MS = 1.8;
  localparam int CYC_FIRST = int'(T_FIRST_MS * CLK_MHZ * 1000.0);
  localparam int CYC_REFRESH = int'(T_REFRESH_MS * CLK_MHZ * 1000.0);

  // Interrupt bit positions
  localparam int IRQ_GNEW_BIT = 0;
  localparam int IRQ_PNEW_LSB = 1;
endpackage : tas_pkg

// file: verilog/tas_sequencer.sv
// Module: telemetry conversion sequencer with APB registers
// How it works
// - Selector field picks global input; mode field picks single-shot or continuous.
// - Selector also offers return currents, input voltage, port output voltages.
// - First global result lands about 3.6 ms after request.
// - Continuous mode refreshes global result every 1.8 ms while enabled.
// - New-data flag sets whenever a fresh global result arrives.
// - Temperature code is offset binary about 2048, four codes per kelvin.
// - Per-port result refreshes every 1.8 ms in power-up or on.
// - Per-port source-current code is offset binary about 2048.
// - Return-current code is offset binary about 2048, 100 uV steps.
// - Continuous voltage readings choose high or low gain.
// - Voltage codes offset about 2048, 35.2 or 17.6 mV per code.
`timescale 1ns/1ps
module tas_sequencer #(
  parameter int NPORTS = 5,
  parameter int FIRST_CYC = tas_pkg::CYC_FIRST,
  parameter int REFRESH_CYC = tas_pkg::CYC_REFRESH
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] temp_code,
  input wire logic [11:0] vin_code_lo,
  input wire logic [11:0] vin_code_hi,
  input wire logic [NPORTS*12-1:0] iret_code,
  input wire logic [NPORTS*12-1:0] vout_code_lo,
  input wire logic [NPORTS*12-1:0] vout_code_hi,
  input wire logic [NPORTS*12-1:0] isrc_code,
  input wire logic [NPORTS-1:0] port_powering,
  output logic irq
);
  localparam int TW = 20;

  if (NPORTS < 1 || NPORTS > 6) begin : g_chk_nports
    $error("NPORTS must be 1 to 6");
  end
  if (FIRST_CYC < 2 || FIRST_CYC >= (1 << TW)) begin : g_chk_first
    $error("FIRST_CYC range");
  end
  if (REFRESH_CYC < 2 || REFRESH_CYC >= (1 << TW)) begin : g_chk_refresh
    $error("REFRESH range");
  end

  // ----------------------------------------------------------------
  // Input synchronisers (converter codes come from analog clocking)
  // ----------------------------------------------------------------
  localparam int SW = 36 + NPORTS * 49;
  logic [SW-1:0] raw;
  logic [SW-1:0] s1_r;
  logic [SW-1:0] s2_r;
  logic [SW-1:0] s3_r;
  logic [SW-1:0] code_r;
  logic [SW-1:0] code_nxt;
  assign raw = {port_powering, isrc_code, vout_code_hi, vout_code_lo,
                iret_code, vin_code_hi, vin_code_lo, temp_code};

  // A code word may tear while it changes; take it once it stands still
  always_comb begin
    code_nxt = code_r;
    if (s2_r == s3_r) begin
      code_nxt = s2_r;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      code_r <= '0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      code_r <= code_nxt;
    end
  end

  function automatic logic [11:0] slice12(input logic [SW-1:0] v,
                                          input int idx);
    slice12 = v[idx*12 +: 12];
  endfunction : slice12

  logic [NPORTS-1:0] pow_s;
  assign pow_s = s2_r[SW-1 -: NPORTS];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic pdat_hit(input logic [7:0] a);
    pdat_hit = (a >= tas_pkg::OFF_PDAT0) && (a[1:0] == 2'h0) &&
               (a < 8'(tas_pkg::OFF_PDAT0 + 8'(NPORTS * 4)));
  endfunction : pdat_hit

  // ----------------------------------------------------------------
  // Global converter control
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {G_IDLE, G_FIRST, G_CONT} tas_gstate_t;
  tas_gstate_t gst_r;
  tas_gstate_t gst_nxt;
  logic [3:0] sel_r;
  logic [3:0] sel_nxt;
  logic [1:0] mode_r;
  logic [1:0] mode_nxt;
  logic gain_r;
  logic gain_nxt;
  logic [11:0] gdat_r;
  logic [11:0] gdat_nxt;
  logic gnew_r;
  logic gnew_nxt;
  logic [TW-1:0] gcnt_r;
  logic [TW-1:0] gcnt_nxt;
  logic cfg_wr;
  logic start_req;
  logic gdone;
  logic [11:0] gsample;

  assign cfg_wr = wr_en && hit(paddr, tas_pkg::OFF_GCFG);
  assign start_req = cfg_wr && pwdata[tas_pkg::GCFG_START_BIT];

  // Source mux; unused selector codes read mid-scale
  always_comb begin
    gsample = tas_pkg::CODE_MID;
    if (sel_r == tas_pkg::SEL_TEMP) begin
      gsample = slice12(code_r, 0);
    end else if (sel_r == tas_pkg::SEL_VIN) begin
      gsample = gain_r ? slice12(code_r, 2)
                       : slice12(code_r, 1);
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        if (sel_r == 4'(tas_pkg::SEL_IRET0 + 4'(p))) begin
          gsample = slice12(code_r, 3 + p);
        end
        if (sel_r == 4'(tas_pkg::SEL_VOUT0 + 4'(p))) begin
          gsample = gain_r ? slice12(code_r, 3 + 2 * NPORTS + p)
                           : slice12(code_r, 3 + NPORTS + p);
        end
      end
    end
  end

  assign gdone = (gst_r != G_IDLE) && (gcnt_r == '0);

  always_comb begin
    gst_nxt = gst_r;
    sel_nxt = sel_r;
    mode_nxt = mode_r;
    gain_nxt = gain_r;
    gdat_nxt = gdat_r;
    gnew_nxt = gnew_r;
    gcnt_nxt = (gcnt_r == '0) ? '0 : gcnt_r - TW'(1);
    // Reading the data word consumes the flag
    if (rd_en && hit(paddr, tas_pkg::OFF_GDAT)) begin
      gnew_nxt = 1'b0;
    end
    case (gst_r)
      G_IDLE: begin
      end
      G_FIRST, G_CONT: begin
        if (gdone) begin
          gdat_nxt = gsample;
          gnew_nxt = 1'b1;
          if (mode_r == tas_pkg::MODE_CONT) begin
            gst_nxt = G_CONT;
            gcnt_nxt = TW'(REFRESH_CYC - 1);
          end else begin
            gst_nxt = G_IDLE;
          end
        end else if (mode_r == tas_pkg::MODE_OFF) begin
          gst_nxt = G_IDLE;
        end
      end
      default: gst_nxt = G_IDLE;
    endcase
    if (cfg_wr) begin
      sel_nxt = pwdata[tas_pkg::GCFG_SEL_LSB +: tas_pkg::GCFG_SEL_W];
      mode_nxt = pwdata[tas_pkg::GCFG_MODE_LSB +: 2];
      // Gain only matters in continuous mode; single-shot forces low
      gain_nxt = pwdata[tas_pkg::GCFG_GAIN_BIT] &&
                 (pwdata[tas_pkg::GCFG_MODE_LSB +: 2] == tas_pkg::MODE_CONT);
      if (start_req && pwdata[tas_pkg::GCFG_MODE_LSB +: 2] !=
          tas_pkg::MODE_OFF) begin
        gst_nxt = G_FIRST;
        gcnt_nxt = TW'(FIRST_CYC - 1);
      end else if (pwdata[tas_pkg::GCFG_MODE_LSB +: 2] ==
                   tas_pkg::MODE_OFF) begin
        gst_nxt = G_IDLE;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      gst_r <= G_IDLE;
      sel_r <= tas_pkg::GCFG_RESET[3:0];
      mode_r <= tas_pkg::MODE_OFF;
      gain_r <= 1'b0;
      gdat_r <= tas_pkg::GDAT_RESET;
      gnew_r <= 1'b0;
      gcnt_r <= '0;
    end else begin
      gst_r <= gst_nxt;
      sel_r <= sel_nxt;
      mode_r <= mode_nxt;
      gain_r <= gain_nxt;
      gdat_r <= gdat_nxt;
      gnew_r <= gnew_nxt;
      gcnt_r <= gcnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Per-port source-current converters
  // ----------------------------------------------------------------
  logic ptick;
  logic [NPORTS*12-1:0] pdat_r;
  logic [NPORTS*12-1:0] pdat_nxt;
  logic [NPORTS-1:0] pupd;

  tas_tick #(.W(TW)) u_ptick (
    .core_clk(core_clk),
    .reset(reset),
    .restart(1'b0),
    .period(TW'(REFRESH_CYC)),
    .tick(ptick)
  );

  always_comb begin
    pdat_nxt = pdat_r;
    pupd = '0;
    for (int p = 0; p < NPORTS; p++) begin
      if (ptick && pow_s[p]) begin
        pdat_nxt[p*12 +: 12] =
            slice12(code_r, 3 + 3 * NPORTS + p);
        pupd[p] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pdat_r <= {NPORTS{tas_pkg::CODE_MID}};
    end else begin
      pdat_r <= pdat_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: sticky status, enable, write-one-to-clear
  // ----------------------------------------------------------------
  localparam int IW = NPORTS + 1;
  logic [IW-1:0] ist_r;
  logic [IW-1:0] ist_nxt;
  logic [IW-1:0] ien_r;
  logic [IW-1:0] ien_nxt;
  logic [IW-1:0] iset;

  assign iset = {pupd, gdone};

  always_comb begin
    ist_nxt = ist_r;
    ien_nxt = ien_r;
    if (wr_en && hit(paddr, tas_pkg::OFF_IRQ_CLR)) begin
      ist_nxt = ist_r & ~pwdata[IW-1:0];
    end
    ist_nxt = ist_nxt | iset; // Set wins over a same-cycle clear
    if (wr_en && hit(paddr, tas_pkg::OFF_IRQ_EN)) begin
      ien_nxt = pwdata[IW-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ist_r <= '0;
      ien_r <= '0;
      irq <= 1'b0;
    end else begin
      ist_r <= ist_nxt;
      ien_r <= ien_nxt;
      irq <= |(ist_nxt & ien_nxt);
    end
  end

  // ----------------------------------------------------------------
  // Read mux and error answer
  // ----------------------------------------------------------------
  logic mapped;
  always_comb begin
    prdata = 32'h00000000;
    mapped = 1'b1;
    if (hit(paddr, tas_pkg::OFF_GCFG)) begin
      prdata[tas_pkg::GCFG_SEL_LSB +: tas_pkg::GCFG_SEL_W] = sel_r;
      prdata[tas_pkg::GCFG_MODE_LSB +: 2] = mode_r;
      prdata[tas_pkg::GCFG_GAIN_BIT] = gain_r;
      prdata[tas_pkg::GCFG_START_BIT] = (gst_r != G_IDLE);
    end else if (hit(paddr, tas_pkg::OFF_GDAT)) begin
      prdata[11:0] = gdat_r;
      prdata[tas_pkg::GDAT_NEW_BIT] = gnew_r;
    end else if (pdat_hit(paddr)) begin
      for (int p = 0; p < NPORTS; p++) begin
        if (paddr == 8'(tas_pkg::OFF_PDAT0 + 8'(p * 4))) begin
          prdata[11:0] = pdat_r[p*12 +: 12];
        end
      end
    end else if (hit(paddr, tas_pkg::OFF_IRQ_STAT)) begin
      prdata[IW-1:0] = ist_r;
    end else if (hit(paddr, tas_pkg::OFF_IRQ_EN)) begin
      prdata[IW-1:0] = ien_r;
    end else if (hit(paddr, tas_pkg::OFF_IRQ_CLR)) begin
      prdata = 32'h00000000;
    end else if (hit(paddr, tas_pkg::OFF_PSTATE)) begin
      prdata[NPORTS-1:0] = pow_s;
    end else begin
      mapped = 1'b0;
    end
  end
  assign pslverr = psel && penable && !mapped;
endmodule : tas_sequencer

// file: verilog/tas_tick.sv
// Module: free-running interval timer with programmable period
`timescale 1ns/1ps
module tas_tick #(
  parameter int W = 20
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic restart,
  input wire logic [W-1:0] period,
  output logic tick
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic tick_nxt;

  always_comb begin
    cnt_nxt = cnt_r - W'(1);
    tick_nxt = 1'b0;
    if (restart) begin
      cnt_nxt = period - W'(1);
    end else if (cnt_r == '0) begin
      cnt_nxt = period - W'(1);
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick <= tick_nxt;
    end
  end
endmodule : tas_tick
